// ===== src/iou_defs.svh
`ifndef IOU_DEFS_SVH
`define IOU_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOU_CLK_MHZ        250
`define IOU_INT_RATE_HZ    2000
`define IOU_TICK_CYCLES    ((`IOU_CLK_MHZ * 1000000) / `IOU_INT_RATE_HZ)
`define IOU_DELAY_MS       5
`define IOU_DELAY_SAMPLES  ((`IOU_DELAY_MS * `IOU_INT_RATE_HZ) / 1000)
`define IOU_DELAY_UNIT     4'h8

// ----------------------------------------------------------------
// Word layout and scaling
// ----------------------------------------------------------------
`define IOU_WORD_W         24
`define IOU_ACC_W          48
`define IOU_RATE_FRAC      14
`define IOU_ANGLE_FRAC     21
`define IOU_INC_SHIFT      4
`define IOU_G_NUM          32'd980665
`define IOU_G_DEN_SHIFT    20
`define IOU_G_DEN          32'd100000
`endif

// ===== src/iou_pkg.sv
package iou_pkg;
  typedef enum logic [3:0] {
    IOU_RAW  = 4'h1,
    IOU_INC  = 4'h2,
    IOU_AVG  = 4'h4,
    IOU_INTG = 4'h8
  } iou_func_t;
  typedef enum logic [1:0] {
    IOU_IDLE = 2'b01,
    IOU_EMIT = 2'b10
  } iou_state_t;
endpackage : iou_pkg

// ===== src/iou_delay.sv
`include "iou_defs.svh"
module iou_delay (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Sample stream
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic [23:0] din,
  output logic      [23:0] dout
);
  import iou_pkg::*;
  localparam int N = `IOU_DELAY_SAMPLES;
  logic [23:0] mem_r [N];
  logic [23:0] mem_nxt [N];
  logic [3:0]  idx_r, idx_nxt;

  // ----------------------------------------------------------------
  // Circular line of 10 internal samples
  // ----------------------------------------------------------------
  always_comb begin
    mem_nxt = mem_r;
    idx_nxt = idx_r;
    if (tick) begin
      mem_nxt[idx_r] = din;
      idx_nxt = (idx_r == 4'(N - 1)) ? 4'h0 : idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N; i++) begin
        mem_r[i] <= 24'h000000;
      end
      idx_r <= 4'h0;
    end else begin
      mem_r <= mem_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Oldest slot is the one about to be overwritten: 5 ms back
  assign dout = enable ? mem_r[idx_r] : din;
endmodule : iou_delay

// ===== src/iou_proc.sv
`include "iou_defs.svh"
module iou_proc (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // Configuration
  input  wire logic [3:0]      gyro_unit,
  input  wire iou_pkg::iou_func_t func,
  input  wire logic            is_accel,
  input  wire logic [11:0]     tx_rate,
  // Filtered sample input, one per internal tick
  input  wire logic [23:0]     sample,
  // Result to datagram transmitter
  output logic                 tick_o,
  output logic                 out_valid,
  output logic [23:0]          out_word,
  output logic [7:0]           out_byte0,
  output logic [7:0]           out_byte1,
  output logic [7:0]           out_byte2
);
  import iou_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [47:0] sext(input logic [23:0] v);
    return {{24{v[23]}}, v};
  endfunction : sext

  // Rate LSB 2^-14 times 1/2000 s onto an angle LSB of 2^-21: times 8/125.
  // An exact ratio, so a shift cannot replace it without drift.
  function automatic logic [47:0] ang_scale(input logic [47:0] v);
    logic signed [55:0] p;
    p = 56'(signed'(v)) * 56'sh8;
    return 48'(p / 56'sh7D);
  endfunction : ang_scale

  // Velocity scaling by 9.80665, fixed point
  function automatic logic [47:0] gscale(input logic [47:0] v);
    logic signed [79:0] p;
    p = 80'(signed'(v)) * 80'(signed'(`IOU_G_NUM));
    return 48'(p / 80'(signed'(`IOU_G_DEN)));
  endfunction : gscale

  // ----------------------------------------------------------------
  // Internal 2000/s tick
  // ----------------------------------------------------------------
  logic [16:0] div_r, div_nxt;
  logic        tick;
  always_comb begin
    div_nxt = (div_r == 17'(`IOU_TICK_CYCLES - 1)) ? 17'h00000 : div_r + 17'h00001;
  end
  assign tick = (div_r == 17'h00000);

  // ----------------------------------------------------------------
  // Optional gyro delay
  // ----------------------------------------------------------------
  logic        dly_en;
  logic [23:0] smp;
  assign dly_en = !is_accel && (gyro_unit >= `IOU_DELAY_UNIT);
  iou_delay u_dly (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick),
    .enable (dly_en),
    .din    (sample),
    .dout   (smp)
  );

  // ----------------------------------------------------------------
  // Interval and accumulators
  // ----------------------------------------------------------------
  logic [11:0] n_cfg;
  logic [11:0] cnt_r, cnt_nxt;
  logic [47:0] sum_r, sum_nxt;
  logic [47:0] int_r, int_nxt;
  logic [47:0] fin;
  logic [23:0] word_r, word_nxt;
  logic        vld_r, vld_nxt;
  logic        tk_r;
  iou_state_t  st_r, st_nxt;

  // Zero or too large a rate would stall; clamp to one sample
  assign n_cfg = (tx_rate == 12'h000 || tx_rate > 12'(`IOU_INT_RATE_HZ)) ? 12'h001 :
                 12'(`IOU_INT_RATE_HZ / 32'(tx_rate));

  always_comb begin
    cnt_nxt  = cnt_r;
    sum_nxt  = sum_r;
    int_nxt  = int_r;
    word_nxt = word_r;
    vld_nxt  = 1'b0;
    st_nxt   = st_r;
    fin      = sum_r + sext(smp);
    unique case (st_r)
      IOU_IDLE: begin
        if (tick) begin
          int_nxt = int_r + sext(smp);
          if (cnt_r + 12'h001 >= n_cfg) begin
            cnt_nxt = 12'h000;
            sum_nxt = 48'h000000000000;
            st_nxt  = IOU_EMIT;
            sum_nxt = fin;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
            sum_nxt = fin;
          end
        end
      end
      IOU_EMIT: begin
        // Quantize once, from the wide sum or integrator, to avoid drift; IOU_RAW passes smp through
        unique case (func)
          IOU_RAW:  word_nxt = smp;
          IOU_AVG:  word_nxt = 24'(signed'(sum_r) / signed'(48'(n_cfg)));
          IOU_INC:  word_nxt = is_accel ? 24'(gscale(sum_r) >>> `IOU_INC_SHIFT)
                                        : 24'(ang_scale(sum_r));
          IOU_INTG: word_nxt = is_accel ? 24'(gscale(int_r) >>> `IOU_INC_SHIFT)
                                        : 24'(ang_scale(int_r));
          default:  word_nxt = smp;
        endcase
        sum_nxt = 48'h000000000000;
        vld_nxt = 1'b1;
        st_nxt  = IOU_IDLE;
      end
      default: st_nxt = IOU_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r  <= 17'h00000;
      cnt_r  <= 12'h000;
      sum_r  <= 48'h000000000000;
      int_r  <= 48'h000000000000;
      word_r <= 24'h000000;
      vld_r  <= 1'b0;
      tk_r   <= 1'b0;
      st_r   <= IOU_IDLE;
    end else begin
      div_r  <= div_nxt;
      cnt_r  <= cnt_nxt;
      sum_r  <= sum_nxt;
      int_r  <= int_nxt;
      word_r <= word_nxt;
      vld_r  <= vld_nxt;
      tk_r   <= tick;
      st_r   <= st_nxt;
    end
  end

  // Three bytes, most significant first
  assign tick_o    = tk_r;
  assign out_valid = vld_r;
  assign out_word  = word_r;
  assign out_byte0 = word_r[23:16];
  assign out_byte1 = word_r[15:8];
  assign out_byte2 = word_r[7:0];
endmodule : iou_proc

// ===== test/iou_proc_asserts.sv
module iou_proc_asserts (
  // Clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // Configuration and samples
  input wire logic [3:0]         gyro_unit,
  input wire iou_pkg::iou_func_t func,
  input wire logic               is_accel,
  input wire logic [11:0]        tx_rate,
  input wire logic [23:0]        sample,
  // Results
  input wire logic               tick_o,
  input wire logic               out_valid,
  input wire logic [23:0]        out_word,
  input wire logic [7:0]         out_byte0,
  input wire logic [7:0]         out_byte1,
  input wire logic [7:0]         out_byte2
);
  import iou_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Gyro unit 8 or more delays gyro data only
  wire logic no_dly = is_accel || (gyro_unit < 4'h8);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  valid_after_tick_a: assert property (out_valid |-> $past(tick_o))
    else $error("result without tick");
  every_tick_a: assert property (tick_o && tx_rate == 12'h7D0 |=> out_valid)
    else $error("n of one missed a result");
  tick_pulse_a: assert property (tick_o |=> !tick_o [*8])
    else $error("tick too wide");
  valid_pulse_a: assert property (out_valid |=> !out_valid [*8])
    else $error("result pulse too wide");
  byte_order_a: assert property (1'b1 |-> {out_byte0, out_byte1, out_byte2} == out_word)
    else $error("bytes not MSB first");
  word_hold_a: assert property (!out_valid |-> $stable(out_word))
    else $error("word changed between results");
  raw_pass_a: assert property (out_valid && func == IOU_RAW && no_dly
    |-> out_word == $past(sample, 2)) else $error("raw word wrong");
  avg_one_a: assert property (out_valid && func == IOU_AVG && no_dly && tx_rate == 12'h7D0
    |-> out_word == $past(sample, 2)) else $error("average of one wrong");
  cover property (out_valid && func == IOU_RAW);
  cover property (out_valid && func == IOU_INTG);
  cover property (out_valid && is_accel);
endmodule : iou_proc_asserts

bind iou_proc iou_proc_asserts u_chk (.clk, .resetn, .gyro_unit, .func, .is_accel, .tx_rate,
  .sample, .tick_o, .out_valid, .out_word, .out_byte0, .out_byte1, .out_byte2);

// ===== test/iou_host_model.sv
module iou_host_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Datagram bytes
  input wire logic        out_valid,
  input wire logic [7:0]  out_byte0,
  input wire logic [7:0]  out_byte1,
  input wire logic [7:0]  out_byte2,
  // Reassembled word
  output logic     [23:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  // Host only trusts bytes in the valid cycle, as a receiver would
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) got <= 24'h000000;
    else if (out_valid) got <= {out_byte0, out_byte1, out_byte2};
  end
endmodule : iou_host_model

// ===== test/iou_proc_tb_top.sv
module iou_proc_tb_top;
  import iou_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  gyro_unit = 4'h0;
  iou_func_t   func = IOU_RAW;
  logic        is_accel = 1'b0;
  logic [11:0] tx_rate = 12'h7D0;
  logic [23:0] sample = 24'h000000;
  logic        tick_o;
  logic        out_valid;
  logic [23:0] out_word;
  logic [23:0] got;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  int          n_fail = 0;
  int          n_compared = 0;
  always #2 clk = ~clk;
  iou_proc dut (.clk(clk), .resetn(resetn), .gyro_unit(gyro_unit), .func(func),
    .is_accel(is_accel), .tx_rate(tx_rate), .sample(sample), .tick_o(tick_o),
    .out_valid(out_valid), .out_word(out_word), .out_byte0(b0), .out_byte1(b1), .out_byte2(b2));
  iou_host_model host (.clk(clk), .resetn(resetn), .out_valid(out_valid), .out_byte0(b0),
    .out_byte1(b1), .out_byte2(b2), .got(got));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Reset restarts the divider, so one tick lands on the first edge; long intervals won't fit
  task run_one(input iou_func_t f, input logic [3:0] gu, input logic acc,
               input logic [23:0] s, input logic [23:0] e);
    int i;
    @(posedge clk);
    #1;
    resetn = 1'b0;
    func = f;
    gyro_unit = gu;
    is_accel = acc;
    sample = s;
    @(posedge clk);
    #1;
    resetn = 1'b1;
    i = 0;
    while (out_valid !== 1'b1 && i < 8) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 8) begin
      n_fail++;
      complete_run();
    end else begin
      // Tick on the first edge after release, result on the second
      check(24'(i), 24'h000002);
      check(out_word, e);
      @(posedge clk);
      #1;
      check(got, e);
    end
  endtask : run_one
  task scn_raw;  run_one(IOU_RAW, 4'h0, 1'b0, 24'h800001, 24'h800001); endtask : scn_raw
  task scn_avg;  run_one(IOU_AVG, 4'h0, 1'b0, 24'hFFF000, 24'hFFF000); endtask : scn_avg
  task scn_inc;  run_one(IOU_INC, 4'h0, 1'b0, 24'h000100, 24'h000010); endtask : scn_inc
  task scn_intg; run_one(IOU_INTG, 4'h0, 1'b0, 24'hFFFF00, 24'hFFFFF0); endtask : scn_intg
  task scn_dly;  run_one(IOU_RAW, 4'h8, 1'b0, 24'h123456, 24'h000000); endtask : scn_dly
  task scn_ainc; run_one(IOU_INC, 4'h8, 1'b1, 24'h100000, 24'h09CE80); endtask : scn_ainc
  task scn_aint; run_one(IOU_INTG, 4'h0, 1'b1, 24'h100000, 24'h09CE80); endtask : scn_aint
  initial begin
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    scn_raw();
    scn_avg();
    scn_inc();
    scn_intg();
    scn_dly();
    scn_ainc();
    scn_aint();
    complete_run();
  end
endmodule : iou_proc_tb_top
